/* logic/nfc_host.sv */
// Purpose: host controller issuing reset, ident, status and array ops
// Assumes: x8 device, apb slave for software, one clock
// Notes: write strobe pulses last one phase high and one phase low; read pulses stay high one phase plus a settle gap
// Functional notes
// - cycle one sends column 7..0, cycle two column 11..8, upper nibble low.
// - last column 2111 goes out as 3Fh then 08h.
// - cycle three page 5..0 and block 1..0, then block 9..2, then block 10.
// - full five cycles for read and program, two for random reads.
// - with column bit 11 set, column bits 10..6 are forced to zero.
// - chip select low, proper latch enable and write strobe per cycle.
// - busy device only gets reset or status commands.
// - ident read is 90h plus one 00h address cycle.
// - both latches low while ident bytes are strobed out one per strobe.
// - polling issues 70h once then only re-strobes.
// - program/erase end with a status read for pass check.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module nfc_host
   import nfc_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chip_sel_n,
   output logic cmd_latch,
   output logic addr_latch,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic [7:0] io_out,
   output logic io_oe,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [7:0] io_meta, io_sync;
   logic rb_meta, rb_sync;
   always_ff @(posedge mclk) begin
      io_meta <= io_in;
      io_sync <= io_meta;
      rb_meta <= ready_busy_n;
      rb_sync <= rb_meta;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   nfc_state_type state;
   logic [2:0] op;
   logic [11:0] column_addr;
   logic [16:0] block_addr;
   logic [5:0] page_addr;
   logic [31:0] ident;
   logic [7:0] operation_status;
   logic [2:0] cyc_idx;
   logic [2:0] cyc_last;
   logic [3:0] phase_cnt;
   logic half;
   logic busy_flag;
   logic stat_valid;
   logic [1:0] settle_cnt;
   logic [2:0] wb_cnt;
   // apb decode
   wire apb_wr = psel && penable && pwrite;
   wire apb_rd_ctrl = apb_wr && (paddr == NFC_REG_CTRL);
   wire start = apb_rd_ctrl && !busy_flag;
   wire hit = (paddr == NFC_REG_CTRL) || (paddr == NFC_REG_COLUMN) ||
              (paddr == NFC_REG_ROW) || (paddr == NFC_REG_STATE) ||
              (paddr == NFC_REG_IDENT) || (paddr == NFC_REG_OPSTAT);
   // the slave answers in its first access cycle
   assign pready = psel && penable;
   assign pslverr = psel && penable && !hit;
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         NFC_REG_CTRL: prdata = {29'h0000_0000, op};
         NFC_REG_COLUMN: prdata = {20'h0_0000, column_addr};
         NFC_REG_ROW: prdata = {9'h000, block_addr, page_addr};
         NFC_REG_STATE: prdata = {29'h0000_0000, stat_valid, !rb_sync, busy_flag};
         NFC_REG_IDENT: prdata = ident;
         NFC_REG_OPSTAT: prdata = {24'h00_0000, operation_status};
         default: prdata = 32'h0000_0000;
      endcase
   end
   // column with bit 11 set forces bits 10..6 low
   wire [11:0] col_safe = pwdata[11] ? {pwdata[11], 5'h00, pwdata[5:0]} : pwdata[11:0];
   always_ff @(posedge mclk) begin
      if (srst) begin
         column_addr <= 12'h000;
         block_addr <= 17'h0_0000;
         page_addr <= 6'h00;
      end else if (apb_wr && !busy_flag) begin
         if (paddr == NFC_REG_COLUMN) column_addr <= col_safe;
         if (paddr == NFC_REG_ROW) begin
            page_addr <= pwdata[5:0];
            block_addr <= pwdata[22:6];
         end
      end
   end

   // ------------------------------------------------------------
   // sequence selection
   // ------------------------------------------------------------
   wire [7:0] first_cmd = (op == NFC_OP_RESET) ? NFC_CMD_RESET :
                          (op == NFC_OP_IDENT) ? NFC_CMD_IDENT :
                          (op == NFC_OP_STATUS) ? NFC_CMD_STATUS :
                          (op == NFC_OP_READ) ? NFC_CMD_READ :
                          (op == NFC_OP_RND_READ) ? NFC_CMD_RND_READ :
                          (op == NFC_OP_PROG) ? NFC_CMD_PROG : NFC_CMD_ERASE;
   wire [7:0] second_cmd = (op == NFC_OP_READ) ? NFC_CMD_READ_GO :
                           (op == NFC_OP_RND_READ) ? NFC_CMD_RND_READ_GO :
                           (op == NFC_OP_PROG) ? NFC_CMD_PROG_GO : NFC_CMD_ERASE_GO;
   wire has_addr = (op != NFC_OP_RESET) && (op != NFC_OP_STATUS);
   wire has_cmd2 = (op >= NFC_OP_READ);
   // erase starts at cycle three; random read stops at two; ident one
   wire [2:0] cyc_first = (op == NFC_OP_ERASE) ? 3'd2 : 3'd0;
   wire [2:0] cyc_end = (op == NFC_OP_IDENT) ? 3'd0 :
                        (op == NFC_OP_RND_READ) ? 3'd1 : 3'd4;
   // address byte for each cycle
   wire [7:0] addr_byte = (op == NFC_OP_IDENT) ? NFC_ID_DUMMY :
                          (cyc_idx == 3'd0) ? column_addr[7:0] :
                          (cyc_idx == 3'd1) ? {4'h0, column_addr[11:8]} :
                          (cyc_idx == 3'd2) ? {block_addr[1:0], page_addr} :
                          (cyc_idx == 3'd3) ? block_addr[9:2] :
                          {7'h00, block_addr[10]};
   // ------------------------------------------------------------
   // strobe timing: phase counter, half selects low/high part
   // ------------------------------------------------------------
   wire phase_end = (phase_cnt == NFC_PHASE_CYC - 4'd1);
   wire pulse_done = phase_end && half;
   // read data crosses two flops, so each read pulse is followed by a settle gap
   wire settled = (settle_cnt == 2'd0);
   wire take = (settle_cnt == 2'd1);
   wire reading = (state == NFC_RDID) || (state == NFC_RDST);
   wire strobing = ((state == NFC_CMD1) || (state == NFC_ADDR) || (state == NFC_CMD2) ||
                   reading) && settled;

   // settle count: the byte sits in io_sync one cycle after the read strobe rises
   always_ff @(posedge mclk) begin
      if (srst) begin
         settle_cnt <= 2'd0;
      end else if (reading && pulse_done) begin
         settle_cnt <= 2'd2;
      end else if (!settled) begin
         settle_cnt <= settle_cnt - 2'd1;
      end
   end

   // ready/busy lags the confirming strobe; its level is trusted only after a few cycles
   always_ff @(posedge mclk) begin
      if (srst || state != NFC_WAIT) begin
         wb_cnt <= 3'd0;
      end else if (wb_cnt != NFC_WB_CYC) begin
         wb_cnt <= wb_cnt + 3'd1;
      end
   end
   wire wb_over = (wb_cnt == NFC_WB_CYC);

   always_ff @(posedge mclk) begin
      if (srst || !strobing) begin
         phase_cnt <= 4'h0;
         half <= 1'b0;
      end else if (phase_end) begin
         phase_cnt <= 4'h0;
         half <= !half;
      end else begin
         phase_cnt <= phase_cnt + 4'd1;
      end
   end

   // ------------------------------------------------------------
   // main sequencer
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= NFC_IDLE;
         op <= NFC_OP_RESET;
         cyc_idx <= 3'd0;
         cyc_last <= 3'd0;
         ident <= 32'h0000_0000;
         operation_status <= NFC_OPSTAT_RESET;
         busy_flag <= 1'b0;
         stat_valid <= 1'b0;
      end else begin
         unique case (state)
            NFC_IDLE: begin
               // only reset and status go out while device busy
               if (start && (rb_sync || pwdata[2:0] == NFC_OP_RESET ||
                   pwdata[2:0] == NFC_OP_STATUS)) begin
                  op <= pwdata[2:0];
                  busy_flag <= 1'b1;
                  state <= NFC_CMD1;
               end
            end
            NFC_CMD1: if (pulse_done) begin
               cyc_idx <= cyc_first;
               cyc_last <= cyc_end;
               if (has_addr) state <= NFC_ADDR;
               else if (op == NFC_OP_STATUS) state <= NFC_RDST;
               else state <= NFC_WAIT;
            end
            NFC_ADDR: if (pulse_done) begin
               if (cyc_idx == cyc_last) begin
                  cyc_idx <= 3'd0;
                  if (op == NFC_OP_IDENT) state <= NFC_RDID;
                  else state <= has_cmd2 ? NFC_CMD2 : NFC_WAIT;
               end else begin
                  cyc_idx <= cyc_idx + 3'd1;
               end
            end
            NFC_CMD2: if (pulse_done) state <= NFC_WAIT;
            NFC_WAIT: begin
               // a reset order may cut a running operation short
               if (apb_rd_ctrl && pwdata[2:0] == NFC_OP_RESET) begin
                  op <= NFC_OP_RESET;
                  state <= NFC_CMD1;
               end else if (wb_over && rb_sync) begin
                  // program and erase close with a status read
                  if (op == NFC_OP_PROG || op == NFC_OP_ERASE) begin
                     op <= NFC_OP_STATUS;
                     state <= NFC_CMD1;
                  end else begin
                     state <= NFC_DONE;
                  end
               end
            end
            NFC_RDID: if (take) begin
               ident <= {io_sync, ident[31:8]};
               if (cyc_idx == NFC_ID_BYTES - 3'd1) state <= NFC_DONE;
               else cyc_idx <= cyc_idx + 3'd1;
            end
            NFC_RDST: if (take) begin
               operation_status <= io_sync;
               stat_valid <= 1'b1;
               // poll by re-strobing only, 70h is not resent
               if (io_sync[NFC_RDY_BIT]) state <= NFC_DONE;
            end
            NFC_DONE: begin
               busy_flag <= 1'b0;
               state <= NFC_IDLE;
            end
            default: state <= NFC_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   wire wr_phase = (state == NFC_CMD1) || (state == NFC_ADDR) || (state == NFC_CMD2);
   wire rd_phase = (state == NFC_RDID) || (state == NFC_RDST);
   always_ff @(posedge mclk) begin
      if (srst) begin
         chip_sel_n <= 1'b1;
         cmd_latch <= 1'b0;
         addr_latch <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         io_out <= 8'h00;
         io_oe <= 1'b0;
      end else begin
         chip_sel_n <= !(wr_phase || rd_phase || state == NFC_WAIT);
         cmd_latch <= (state == NFC_CMD1) || (state == NFC_CMD2);
         addr_latch <= (state == NFC_ADDR);
         write_strobe_n <= !(wr_phase && !half);
         read_strobe_n <= !(rd_phase && !half && settled);
         io_oe <= wr_phase;
         io_out <= (state == NFC_ADDR) ? addr_byte :
                   (state == NFC_CMD2) ? second_cmd : first_cmd;
      end
   end

   // ------------------------------------------------------------
   // pin protocol checks
   // ------------------------------------------------------------
   // a write pulse is one cycle low, then high with the same latch
   sequence s_cmd_low;
      cmd_latch && !write_strobe_n;
   endsequence
   sequence s_cmd_high;
      cmd_latch && write_strobe_n;
   endsequence
   sequence s_addr_low;
      addr_latch && !write_strobe_n;
   endsequence
   sequence s_addr_high;
      addr_latch && write_strobe_n;
   endsequence

   a_cmd_latched: assert property (s_cmd_low |=> s_cmd_high)
      else $error("command latch fell before the write strobe rose");

   a_addr_latched: assert property (s_addr_low |=> s_addr_high)
      else $error("address latch fell before the write strobe rose");

   // the byte must not move under a rising write strobe
   a_write_hold: assert property (!write_strobe_n |=> $stable(io_out))
      else $error("bus byte changed during a write pulse");

   a_strobe_excl: assert property (!(!write_strobe_n && !read_strobe_n))
      else $error("write and read strobes low together");

   a_latch_excl: assert property (!(cmd_latch && addr_latch))
      else $error("command and address latch high together");

   a_select_idle: assert property (chip_sel_n |-> write_strobe_n && read_strobe_n && !io_oe)
      else $error("strobe or drive while deselected");

   // host lets go of the bus before the device may drive it
   a_bus_turn: assert property (!read_strobe_n |-> !io_oe)
      else $error("host drives the bus during a read pulse");

   a_id_latches: assert property (!read_strobe_n |-> !cmd_latch && !addr_latch)
      else $error("latch high during a read pulse");

   // polling re-strobes only; no further command cycle
   a_poll_once: assert property ((state == NFC_RDST) && $past(state == NFC_RDST) |-> !cmd_latch)
      else $error("command latch raised while polling status");
endmodule
`default_nettype wire

/* logic/nfc_pkg.sv */
// Purpose: constants for the nand command front-end controller
// Assumes: 25 MHz mclk, apb register access
// Notes: device command codes and register map of the controller
package nfc_pkg;
   // ------------------------------------------------------------
   // device command codes
   // ------------------------------------------------------------
   localparam logic [7:0] NFC_CMD_RESET = 8'hff;
   localparam logic [7:0] NFC_CMD_IDENT = 8'h90;
   localparam logic [7:0] NFC_CMD_STATUS = 8'h70;
   localparam logic [7:0] NFC_CMD_READ = 8'h00;
   localparam logic [7:0] NFC_CMD_READ_GO = 8'h30;
   localparam logic [7:0] NFC_CMD_RND_READ = 8'h05;
   localparam logic [7:0] NFC_CMD_RND_READ_GO = 8'he0;
   localparam logic [7:0] NFC_CMD_PROG = 8'h80;
   localparam logic [7:0] NFC_CMD_PROG_GO = 8'h10;
   localparam logic [7:0] NFC_CMD_ERASE = 8'h60;
   localparam logic [7:0] NFC_CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] NFC_ID_DUMMY = 8'h00;
   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] NFC_REG_CTRL = 8'h00;
   localparam logic [7:0] NFC_REG_COLUMN = 8'h04;
   localparam logic [7:0] NFC_REG_ROW = 8'h08;
   localparam logic [7:0] NFC_REG_STATE = 8'h0c;
   localparam logic [7:0] NFC_REG_IDENT = 8'h10;
   localparam logic [7:0] NFC_REG_OPSTAT = 8'h14;
   // ctrl register: op code in bits 2:0, write starts
   localparam logic [2:0] NFC_OP_RESET = 3'h0;
   localparam logic [2:0] NFC_OP_IDENT = 3'h1;
   localparam logic [2:0] NFC_OP_STATUS = 3'h2;
   localparam logic [2:0] NFC_OP_READ = 3'h3;
   localparam logic [2:0] NFC_OP_RND_READ = 3'h4;
   localparam logic [2:0] NFC_OP_PROG = 3'h5;
   localparam logic [2:0] NFC_OP_ERASE = 3'h6;
   // ------------------------------------------------------------
   // timing: strobe phase length in cycles (>=30 ns)
   // ------------------------------------------------------------
   localparam int NFC_T_PHASE_NS = 40;
   localparam int NFC_CLK_NS = 40;
   localparam logic [3:0] NFC_PHASE_CYC = 4'((NFC_T_PHASE_NS + NFC_CLK_NS - 1) / NFC_CLK_NS);
   localparam logic [2:0] NFC_ID_BYTES = 3'h4;
   // cycles spent in the wait state before the ready/busy level is believed
   localparam logic [2:0] NFC_WB_CYC = 3'd4;
   localparam logic [7:0] NFC_OPSTAT_RESET = 8'h00;
   localparam int NFC_RDY_BIT = 6;
   localparam logic [11:0] NFC_COL_LAST = 12'h83f;
   typedef enum logic [3:0] {
      NFC_IDLE, NFC_CMD1, NFC_ADDR, NFC_CMD2, NFC_WAIT, NFC_RDID, NFC_RDST, NFC_DONE
   } nfc_state_type;
endpackage

/* verif/nfc_dev_model.sv */
// Purpose: behavioural nand device facing the host controller
// Assumes: x8 part, pull-up on ready/busy, no clock of its own
// Notes: logs every latched command and address byte for the bench
`timescale 1ns/1ns
`default_nettype none
module nfc_dev_model #(
   parameter int BUSY_NS = 2000,
   parameter logic [7:0] ID_MFR = 8'h5e, // arbitrary value
   parameter logic [7:0] ID_DEV = 8'h3c // arbitrary value
) (
   input wire logic chip_sel_n,
   input wire logic cmd_latch,
   input wire logic addr_latch,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [7:0] io_out,
   input wire logic wp_n,
   input wire logic fail,
   output logic [7:0] io_in,
   output logic ready_busy_n
);
   logic [8:0] log_q [64];
   int n_log = 0;
   int n_rd = 0;
   int n_abort = 0;
   logic in_id = 0;
   logic [1:0] id_ix = 0;
   logic [7:0] last = 0;
   logic [7:0] dout;
   time t_end = 0;
   logic busy = 0;
   // ------------------------------------------------------------
   // busy window, a reset cuts it short
   // ------------------------------------------------------------
   always #10 busy = ($time < t_end);
   assign ready_busy_n = ~busy;
   // bytes taken on the rising write strobe, only while selected
   always @(posedge write_strobe_n) begin
      if (!chip_sel_n && (cmd_latch || addr_latch)) begin
         log_q[n_log] = {cmd_latch, io_out};
         n_log++;
      end
      if (!chip_sel_n && cmd_latch) begin
         case (io_out)
            8'hff: begin
               if (busy) n_abort++;
               t_end = $time;
               in_id = 0;
            end
            8'h90: if (!busy) begin
               in_id = 1;
               id_ix = 0;
            end
            8'h70: in_id = 0;
            8'h30, 8'h10, 8'hd0: if (!busy) t_end = $time + BUSY_NS;
            default: ;
         endcase
      end
   end
   // one ident byte per read strobe
   always @(posedge read_strobe_n) begin
      if (!chip_sel_n && in_id) begin
         id_ix++;
         n_rd++;
      end
   end
   // status is live, so a held strobe follows busy changes
   assign dout = in_id ? ((id_ix == 0) ? ID_MFR : (id_ix == 1) ? ID_DEV :
      (id_ix == 2) ? 8'h00 : 8'h15) : {wp_n, ~busy, ~busy, 4'h0, fail};
   // released bus shows the inverse of the last byte, never a stale copy
   always @* if (!chip_sel_n && !read_strobe_n) last = dout;
   assign io_in = (!chip_sel_n && !read_strobe_n) ? dout : ~last;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for the nand host controller
// Assumes: apb master with no fixed wait, device model on the pins
// Notes: table rows hold op, address and expected latched bytes
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench
   import nfc_pkg::*;
;
   typedef struct packed {
      logic [2:0] op;
      logic [11:0] col;
      logic [16:0] row;
      logic [3:0] n;
      logic [7:0][8:0] exp;
   } nfc_row_type;
   logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, wp_n = 1, fail = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, er, chip_sel_n, cmd_latch, addr_latch;
   logic write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
   logic [7:0] io_out, io_in;
   int n_errors = 0, tests_run = 0, st, k;
   nfc_row_type rows [7];
   always #20 mclk = ~mclk;
   nfc_host u_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
      .ready_busy_n(ready_busy_n));
   nfc_dev_model u_dev (.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .io_out(io_out), .wp_n(wp_n), .fail(fail),
      .io_in(io_in), .ready_busy_n(ready_busy_n));
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge mclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      j = 0;
      do begin @(posedge mclk); j++; end while (pready !== 1'b1 && j < 50);
      if (j >= 50) n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // start an op and poll the busy bit until it drops
   task run(input logic [2:0] op);
      int j;
      apb(1, NFC_REG_CTRL, {29'h0, op});
      j = 0;
      do begin apb(0, NFC_REG_STATE, 32'h0000_0000); j++; end
      while (rd[0] !== 1'b0 && j < 2000);
      if (j >= 2000) n_errors++;
   endtask
   // watchdog, well past the longest expected run
   initial begin
      #400_000;
      n_errors++;
      end_sim;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rows[0] = '{NFC_OP_RESET, 12'h000, 17'h0_0000, 4'h1, {9'h1ff, 63'h0}};
      rows[1] = '{NFC_OP_READ, 12'h83f, 17'h1_5a45, 4'h7, {9'h100, 9'h03f, 9'h008,
         9'h045, 9'h05a, 9'h001, 9'h130, 9'h000}};
      rows[2] = '{NFC_OP_RND_READ, 12'h123, 17'h1_5a45, 4'h4,
         {9'h105, 9'h023, 9'h001, 9'h1e0, 36'h0}};
      rows[3] = '{NFC_OP_PROG, 12'h8ff, 17'h1_5a45, 4'h8, {9'h180, 9'h03f, 9'h008,
         9'h045, 9'h05a, 9'h001, 9'h110, 9'h170}};
      rows[4] = '{NFC_OP_ERASE, 12'h000, 17'h1_5a45, 4'h6,
         {9'h160, 9'h045, 9'h05a, 9'h001, 9'h1d0, 9'h170, 18'h0}};
      rows[5] = '{NFC_OP_IDENT, 12'h000, 17'h0_0000, 4'h2, {9'h190, 9'h000, 54'h0}};
      rows[6] = '{NFC_OP_STATUS, 12'h000, 17'h0_0000, 4'h1, {9'h170, 63'h0}};
      repeat (3) @(posedge mclk);
      srst <= 0;
      `CHK("idle select", 1'b1, chip_sel_n)
      for (int i = 0; i < 7; i++) begin
         apb(1, NFC_REG_COLUMN, {20'h0, rows[i].col});
         apb(1, NFC_REG_ROW, {15'h0, rows[i].row});
         st = u_dev.n_log;
         run(rows[i].op);
         `CHK("byte count", st + int'(rows[i].n), u_dev.n_log)
         for (int j = 0; j < rows[i].n; j++)
            `CHK("bus byte", rows[i].exp[7-j], u_dev.log_q[st+j])
      end
      `CHK("ident reads", 4, u_dev.n_rd)
      apb(0, NFC_REG_IDENT, 32'h0000_0000);
      `CHK("ident", 32'h1500_3c5e, rd)
      apb(0, NFC_REG_OPSTAT, 32'h0000_0000);
      `CHK("status ok", 8'he0, rd[7:0])
      fail <= 1;
      wp_n <= 0;
      run(NFC_OP_STATUS);
      apb(0, NFC_REG_OPSTAT, 32'h0000_0000);
      `CHK("status fail", 8'h61, rd[7:0])
      apb(0, 8'h40, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, er)
      // erase cut short by a reset while the device is busy
      fail <= 0;
      wp_n <= 1;
      apb(1, NFC_REG_CTRL, {29'h0, NFC_OP_ERASE});
      k = 0;
      while (ready_busy_n !== 1'b0 && k < 500) begin @(posedge mclk); k++; end
      run(NFC_OP_RESET);
      `CHK("aborts", 1, u_dev.n_abort)
      `CHK("ready after", 1'b1, ready_busy_n)
      `CHK("reset byte", 9'h1ff, u_dev.log_q[u_dev.n_log-1])
      end_sim;
   end
endmodule
`default_nettype wire
